// [pcg_consts.svh]
// offsets, field positions, reset values and codes of the peripheral clock gate block
// Overview of operation
// R1: each gate bit drives one unit's clock enable
// R2: access to unclocked unit answers bus fault
// R3: all gate bits reset to zero
// R4: run port gate at 0x108 in run mode
// R5: sleep port gate at 0x118 in sleep
// R6: deep-sleep port gate applies in deep sleep
// R7: deep-sleep port gate at 0x128, resets zero
// R8: auto gating bit selects low-power gate registers
// R9: auto gating clear keeps run gates everywhere
// R10: port gate bits 0..4 are ports A..E
// R11: port gate bits 31:5 read zero, ignored
// R12: peripheral gate bit 16 is timer zero
// R13: peripheral gate bit 4 is sync serial zero
// R14: bits 1, 0 are serial ports one, zero
// R15: peripheral gate bits 15:5, 3:2 read zero
// R16: software enables units first, preserves reserved bits
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH
`define PCG_OFS_RUN_PORT         12'h108
`define PCG_OFS_SLEEP_PORT       12'h118
`define PCG_OFS_DEEP_PORT        12'h128
`define PCG_OFS_PERIPH           12'h104
`define PCG_OFS_RUN_CFG          12'h060
`define PCG_PORT_MASK            32'h0000001F
`define PCG_PERIPH_MASK          32'h00010013
`define PCG_RESET_VAL            32'h00000000
`define PCG_BIT_TIMER_ZERO       16
`define PCG_BIT_SYNC_SERIAL_ZERO 4
`define PCG_BIT_SERIAL_ONE       1
`define PCG_BIT_SERIAL_ZERO      0
`define PCG_BIT_AUTO_GATE        27
`define PCG_RESP_OKAY            2'h0
`define PCG_RESP_SLVERR          2'h2
`define PCG_RESP_DECERR          2'h3
`define PCG_NUM_PORTS            5
`define PCG_NUM_UNITS            9
`endif

// [pcg_pkg.sv]
// types of the peripheral clock gate block
package pcg_pkg;
  typedef enum logic [1:0] {PCG_MODE_RUN, PCG_MODE_SLEEP, PCG_MODE_DEEP} pcg_mode_t;
  typedef enum logic {PCG_BUS_IDLE, PCG_BUS_ACK} pcg_bus_t;
  typedef enum logic [2:0] {
    PCG_REG_NONE, PCG_REG_RUN, PCG_REG_SLEEP, PCG_REG_DEEP, PCG_REG_PERIPH, PCG_REG_CFG
  } pcg_reg_t;
  typedef struct packed {
    pcg_bus_t    busState;
    logic [31:0] readData;
    logic [1:0]  resp;
    logic [4:0]  runPort;
    logic [4:0]  sleepPort;
    logic [4:0]  deepPort;
    logic [31:0] periph;
    logic        autoGate;
    logic [4:0]  portEnable;
    logic [3:0]  unitEnable;
  } pcg_state_t;
  typedef struct packed {
    logic fault;
  } pcg_fault_state_t;
endpackage

// [pcg_fault_check.sv]
// bus fault answer for accesses to unclocked units
`timescale 1ns/1ns
`include "pcg_consts.svh"
module pcg_fault_check #(
  parameter int NUM_UNITS = `PCG_NUM_UNITS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 perValid,
  input  wire logic [3:0]           perUnit,
  input  wire logic [NUM_UNITS-1:0] unitEnable,
  output logic                      perAccept,
  output logic                      perFault
);
  // the unit index is four bits wide, so sixteen units at most
  if (NUM_UNITS < 1 || NUM_UNITS > 16) begin : g_bad_units
    $error("pcg_fault_check: NUM_UNITS out of range");
  end

  pcg_pkg::pcg_fault_state_t st;
  pcg_pkg::pcg_fault_state_t next_st;
  logic unitOn;

  // an index past the last unit counts as unclocked
  always_comb begin
    unitOn = 1'b0;
    if ({1'b0, perUnit} < 5'(NUM_UNITS)) begin
      unitOn = unitEnable[perUnit];
    end
  end

  assign perAccept = perValid & unitOn;

  always_comb begin
    next_st = st;
    next_st.fault = perValid & ~unitOn; // see R2
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign perFault = st.fault;

  gated_fault_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R2
    (ce && perValid && !unitOn) |=> perFault)
    else $error("access to unclocked unit gave no fault");
endmodule

// [pcg_top.sv]
// peripheral clock gate registers, mode selection and bus slave
`timescale 1ns/1ns
`include "pcg_consts.svh"
module pcg_top (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  input  wire logic        sleepMode,
  input  wire logic        deepSleepMode,
  input  wire logic        perValid,
  input  wire logic [3:0]  perUnit,
  output logic             perAccept,
  output logic             perFault,
  output logic      [4:0]  portClockEnable,
  output logic      [3:0]  unitClockEnable
);
  pcg_pkg::pcg_state_t st;
  pcg_pkg::pcg_state_t next_st;
  pcg_pkg::pcg_reg_t   hitReg;
  pcg_pkg::pcg_mode_t  modeNow;
  logic                busReq;
  logic                busDone;
  logic [31:0]         wrWord;
  logic [8:0]          allEnable;

  // one decode shared by the read and write paths
  function automatic pcg_pkg::pcg_reg_t decodeReg(input logic [11:0] addr);
    pcg_pkg::pcg_reg_t r;
    r = pcg_pkg::PCG_REG_NONE;
    case (addr)
      `PCG_OFS_RUN_PORT: begin
        r = pcg_pkg::PCG_REG_RUN;
      end
      `PCG_OFS_SLEEP_PORT: begin
        r = pcg_pkg::PCG_REG_SLEEP;
      end
      `PCG_OFS_DEEP_PORT: begin
        r = pcg_pkg::PCG_REG_DEEP;
      end
      `PCG_OFS_PERIPH: begin
        r = pcg_pkg::PCG_REG_PERIPH;
      end
      `PCG_OFS_RUN_CFG: begin
        r = pcg_pkg::PCG_REG_CFG;
      end
      default: begin
        r = pcg_pkg::PCG_REG_NONE;
      end
    endcase
    return r;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] readValue(input pcg_pkg::pcg_reg_t r,
                                            input pcg_pkg::pcg_state_t s);
    logic [31:0] v;
    v = `PCG_RESET_VAL;
    case (r)
      pcg_pkg::PCG_REG_RUN: begin
        v = {27'h0000000, s.runPort}; // see R10, see R11
      end
      pcg_pkg::PCG_REG_SLEEP: begin
        v = {27'h0000000, s.sleepPort}; // see R11
      end
      pcg_pkg::PCG_REG_DEEP: begin
        v = {27'h0000000, s.deepPort}; // see R11
      end
      pcg_pkg::PCG_REG_PERIPH: begin
        v = s.periph & `PCG_PERIPH_MASK; // see R15
      end
      pcg_pkg::PCG_REG_CFG: begin
        v[`PCG_BIT_AUTO_GATE] = s.autoGate; // see R8
      end
      default: begin
        v = `PCG_RESET_VAL;
      end
    endcase
    return v;
  endfunction

  assign hitReg  = decodeReg(avs_address);
  // read and write are never high together, so either one is the request
  assign busReq  = avs_read | avs_write;
  // waitrequest drops only in a cycle where state can move, else writes would be lost
  assign busDone = busReq & (st.busState == pcg_pkg::PCG_BUS_ACK) & ce;
  assign avs_waitrequest = busReq & ~busDone;
  assign avs_readdata    = st.readData;
  assign avs_response    = st.resp;
  assign wrWord = byteMerge(readValue(hitReg, st), avs_writedata, avs_byteenable);

  // low-power modes follow their own gates only with auto gating on
  always_comb begin
    modeNow = pcg_pkg::PCG_MODE_RUN;
    if (deepSleepMode) begin
      modeNow = pcg_pkg::PCG_MODE_DEEP;
    end else if (sleepMode) begin
      modeNow = pcg_pkg::PCG_MODE_SLEEP;
    end
  end

  always_comb begin
    next_st = st;
    case (st.busState)
      pcg_pkg::PCG_BUS_IDLE: begin
        if (busReq) begin
          next_st.busState = pcg_pkg::PCG_BUS_ACK;
          next_st.readData = avs_read ? readValue(hitReg, st) : `PCG_RESET_VAL;
          next_st.resp = (hitReg == pcg_pkg::PCG_REG_NONE) ? `PCG_RESP_DECERR
                                                           : `PCG_RESP_OKAY;
        end
      end
      pcg_pkg::PCG_BUS_ACK: begin
        if (busReq) begin
          next_st.busState = pcg_pkg::PCG_BUS_IDLE;
          if (avs_write) begin
            case (hitReg)
              pcg_pkg::PCG_REG_RUN: begin
                next_st.runPort = wrWord[4:0]; // see R4, see R11
              end
              pcg_pkg::PCG_REG_SLEEP: begin
                next_st.sleepPort = wrWord[4:0]; // see R5, see R11
              end
              pcg_pkg::PCG_REG_DEEP: begin
                next_st.deepPort = wrWord[4:0]; // see R7, see R11
              end
              pcg_pkg::PCG_REG_PERIPH: begin
                next_st.periph = wrWord & `PCG_PERIPH_MASK; // see R15
              end
              pcg_pkg::PCG_REG_CFG: begin
                next_st.autoGate = wrWord[`PCG_BIT_AUTO_GATE]; // see R8
              end
              default: begin
                next_st.runPort = st.runPort;
              end
            endcase
          end
        end else begin
          // master withdrew the request; drop the pending answer
          next_st.busState = pcg_pkg::PCG_BUS_IDLE;
        end
      end
      default: begin
        next_st.busState = pcg_pkg::PCG_BUS_IDLE;
      end
    endcase
    // see R6, see R8, see R9
    case (st.autoGate ? modeNow : pcg_pkg::PCG_MODE_RUN)
      pcg_pkg::PCG_MODE_RUN: begin
        next_st.portEnable = st.runPort; // see R1, see R4
      end
      pcg_pkg::PCG_MODE_SLEEP: begin
        next_st.portEnable = st.sleepPort; // see R5
      end
      pcg_pkg::PCG_MODE_DEEP: begin
        next_st.portEnable = st.deepPort; // see R6
      end
      default: begin
        next_st.portEnable = st.runPort;
      end
    endcase
    // only the run copy of the unit gates exists, so it governs every mode
    next_st.unitEnable = {st.periph[`PCG_BIT_TIMER_ZERO],       // see R12
                          st.periph[`PCG_BIT_SYNC_SERIAL_ZERO], // see R13
                          st.periph[`PCG_BIT_SERIAL_ONE],       // see R14
                          st.periph[`PCG_BIT_SERIAL_ZERO]};     // see R14
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= '0; // see R3, see R7
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign portClockEnable = st.portEnable; // see R1
  assign unitClockEnable = st.unitEnable; // see R1
  // ports A..E take unit slots 0..4, then serial zero, one, sync serial, timer
  assign allEnable = {st.unitEnable[3], st.unitEnable[2], st.unitEnable[1],
                      st.unitEnable[0], st.portEnable};

  pcg_fault_check #(
    .NUM_UNITS(`PCG_NUM_UNITS)
  ) u_fault (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .ce         (ce),
    .perValid   (perValid),
    .perUnit    (perUnit),
    .unitEnable (allEnable),
    .perAccept  (perAccept),
    .perFault   (perFault)
  );

  reset_clear_a: assert property (@(posedge clk_sys) // see R3
    $rose(rstn) |-> (st.runPort == 5'h00 && st.sleepPort == 5'h00 && st.periph == 32'h0))
    else $error("gate bits not zero after reset");

  deep_reset_a: assert property (@(posedge clk_sys) // see R7
    $rose(rstn) |-> (st.deepPort == 5'h00 && portClockEnable == 5'h00))
    else $error("deep-sleep gates not zero after reset");

  run_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R4
    ($past(ce) && !$past(sleepMode) && !$past(deepSleepMode))
      |-> portClockEnable == $past(st.runPort))
    else $error("run mode port enables wrong");

  sleep_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R5
    ($past(ce) && $past(st.autoGate) && $past(sleepMode) && !$past(deepSleepMode))
      |-> portClockEnable == $past(st.sleepPort))
    else $error("sleep mode port enables wrong");

  deep_mode_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R6
    ($past(ce) && $past(st.autoGate) && $past(deepSleepMode))
      |-> portClockEnable == $past(st.deepPort))
    else $error("deep-sleep port enables wrong");

  no_auto_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R9
    ($past(ce) && !$past(st.autoGate) && ($past(sleepMode) || $past(deepSleepMode)))
      |-> portClockEnable == $past(st.runPort))
    else $error("run gates not kept with auto gating off");

  auto_switch_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R8
    (ce && st.autoGate && sleepMode && !deepSleepMode && st.sleepPort != st.runPort)
      |=> portClockEnable != $past(st.runPort))
    else $error("auto gating did not select sleep gates");

  unit_map_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R12
    $past(ce) |-> unitClockEnable == {$past(st.periph[16]), $past(st.periph[4]),
                                      $past(st.periph[1]), $past(st.periph[0])})
    else $error("unit enables do not follow peripheral gates");

  port_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R10
    (busDone && avs_write && hitReg == pcg_pkg::PCG_REG_RUN && avs_byteenable[0])
      |=> st.runPort == $past(avs_writedata[4:0]))
    else $error("run port gate write not stored");

  port_reserved_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R11
    (busDone && avs_read && (hitReg == pcg_pkg::PCG_REG_RUN || hitReg == pcg_pkg::PCG_REG_SLEEP
      || hitReg == pcg_pkg::PCG_REG_DEEP)) |-> avs_readdata[31:5] == 27'h0)
    else $error("port gate reserved bits not zero");

  periph_reserved_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R15
    (busDone && avs_read && hitReg == pcg_pkg::PCG_REG_PERIPH)
      |-> (avs_readdata[15:5] == 11'h0 && avs_readdata[3:2] == 2'h0))
    else $error("peripheral gate reserved bits not zero");

  periph_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R13
    (busDone && avs_write && hitReg == pcg_pkg::PCG_REG_PERIPH && avs_byteenable == 4'hF)
      |=> st.periph == ($past(avs_writedata) & 32'h00010013))
    else $error("peripheral gate write wrong");

  serial_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R14
    ($past(ce) && $past(st.periph[1:0]) == 2'h3) |-> unitClockEnable[1:0] == 2'h3)
    else $error("serial port enables not following gates");

  bus_answer_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ce && busReq && st.busState == pcg_pkg::PCG_BUS_IDLE) ##1 (ce && busReq)
      |-> !avs_waitrequest)
    else $error("bus answer later than one cycle");

  unmapped_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (busDone && hitReg == pcg_pkg::PCG_REG_NONE) |-> avs_response == 2'h3)
    else $error("unmapped access not refused");

  // a frozen block must not lose or invent a write
  ce_freeze_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !ce |=> $stable(st))
    else $error("state moved while clock enable low");

  write_rdata_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (busDone && avs_write) |-> avs_readdata == 32'h00000000)
    else $error("read data not zero on a write");

  sleep_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R5
    (busDone && avs_write && hitReg == pcg_pkg::PCG_REG_SLEEP && avs_byteenable[0])
      |=> st.sleepPort == $past(avs_writedata[4:0]))
    else $error("sleep port gate write not stored");

  deep_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R7
    (busDone && avs_write && hitReg == pcg_pkg::PCG_REG_DEEP && avs_byteenable[0])
      |=> st.deepPort == $past(avs_writedata[4:0]))
    else $error("deep-sleep port gate write not stored");

  auto_write_a: assert property (@(posedge clk_sys) disable iff (!rstn) // see R8
    (busDone && avs_write && hitReg == pcg_pkg::PCG_REG_CFG
      && avs_byteenable[`PCG_BIT_AUTO_GATE / 8])
      |=> st.autoGate == $past(avs_writedata[`PCG_BIT_AUTO_GATE]))
    else $error("auto gating bit write not stored");
endmodule

// [pcg_unit_model.sv]
// model of the gated peripheral units making access attempts
`timescale 1ns/1ns
module pcg_unit_model (
  input  wire logic       clk_sys,
  input  wire logic [4:0] portClockEnable,
  input  wire logic [3:0] unitClockEnable,
  input  wire logic       perAccept,
  input  wire logic       perFault,
  output logic            perValid,
  output logic      [3:0] perUnit
);
  initial begin
    perValid = 1'b0;
    perUnit  = 4'hF;
  end
  // index flips when idle so a stale unit number is never seen
  task automatic attempt(input logic [3:0] u, output logic acc, output logic flt,
                         output logic clk);
    logic [8:0] en;
    @(posedge clk_sys);
    perValid <= 1'b1;
    perUnit  <= u;
    @(negedge clk_sys);
    en = {unitClockEnable, portClockEnable};
    clk = (u < 4'h9) ? en[u] : 1'b0;
    acc = perAccept;
    @(posedge clk_sys);
    perValid <= 1'b0;
    perUnit  <= ~u;
    @(negedge clk_sys);
    flt = perFault;
  endtask
endmodule

// [peripheral_clock_gating_bench.sv]
// self-checking bench of the peripheral clock gate block
`timescale 1ns/1ns
`include "pcg_consts.svh"
module peripheral_clock_gating_bench;
  logic        clk_sys;
  logic        rstn;
  logic        ce;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        sleepMode;
  logic        deepSleepMode;
  logic        perValid;
  logic [3:0]  perUnit;
  logic        perAccept;
  logic        perFault;
  logic [4:0]  portClockEnable;
  logic [3:0]  unitClockEnable;
  int          err_total;
  int          cmp_count;

  pcg_top i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .sleepMode(sleepMode), .deepSleepMode(deepSleepMode), .perValid(perValid),
    .perUnit(perUnit), .perAccept(perAccept), .perFault(perFault),
    .portClockEnable(portClockEnable), .unitClockEnable(unitClockEnable));

  pcg_unit_model i_unit (
    .clk_sys(clk_sys), .portClockEnable(portClockEnable),
    .unitClockEnable(unitClockEnable), .perAccept(perAccept), .perFault(perFault),
    .perValid(perValid), .perUnit(perUnit));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // master holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic [1:0]  r;
    bus(1'b1, a, d, 4'hF, x, r);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] x;
    logic [1:0]  r;
    bus(1'b0, a, 32'h00000000, 4'hF, x, r);
    chk(x, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // enables lag register and mode by one edge
  task automatic settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic t_reset();
    rdc(`PCG_OFS_RUN_PORT, `PCG_RESET_VAL, `PCG_RESP_OKAY);
    rdc(`PCG_OFS_SLEEP_PORT, `PCG_RESET_VAL, `PCG_RESP_OKAY);
    rdc(`PCG_OFS_DEEP_PORT, `PCG_RESET_VAL, `PCG_RESP_OKAY);
    rdc(`PCG_OFS_PERIPH, `PCG_RESET_VAL, `PCG_RESP_OKAY);
    rdc(`PCG_OFS_RUN_CFG, `PCG_RESET_VAL, `PCG_RESP_OKAY);
    chk({23'h0, unitClockEnable, portClockEnable}, 32'h00000000);
  endtask

  task automatic t_ports();
    logic [31:0] x;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      wr(`PCG_OFS_RUN_PORT, 32'h00000001 << i);
      settle();
      chk({27'h0, portClockEnable}, 32'h00000001 << i);
    end
    wr(`PCG_OFS_RUN_PORT, 32'hFFFFFFFF);
    rdc(`PCG_OFS_RUN_PORT, `PCG_PORT_MASK, `PCG_RESP_OKAY);
    // no lanes enabled: value must survive
    bus(1'b1, `PCG_OFS_RUN_PORT, 32'h00000000, 4'h0, x, r);
    rdc(`PCG_OFS_RUN_PORT, `PCG_PORT_MASK, `PCG_RESP_OKAY);
  endtask

  task automatic t_units();
    int b [4] = '{`PCG_BIT_SERIAL_ZERO, `PCG_BIT_SERIAL_ONE,
                  `PCG_BIT_SYNC_SERIAL_ZERO, `PCG_BIT_TIMER_ZERO};
    wr(`PCG_OFS_PERIPH, 32'hFFFFFFFF);
    rdc(`PCG_OFS_PERIPH, `PCG_PERIPH_MASK, `PCG_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(`PCG_OFS_PERIPH, 32'h00000001 << b[k]);
      settle();
      chk({28'h0, unitClockEnable}, 32'h00000001 << k);
    end
  endtask

  task automatic t_fault();
    logic acc;
    logic flt;
    logic clk;
    logic e;
    wr(`PCG_OFS_RUN_PORT, 32'h00000004);
    wr(`PCG_OFS_PERIPH, 32'h00010001);
    settle();
    for (int u = 0; u < 10; u++) begin
      e = (u == 2 || u == 5 || u == 8);
      i_unit.attempt(u[3:0], acc, flt, clk);
      chk({31'h0, clk}, {31'h0, e});
      chk({31'h0, acc}, {31'h0, e});
      chk({31'h0, flt}, {31'h0, !e});
    end
  endtask

  task automatic mode(input logic s, input logic d, input logic [31:0] e);
    @(posedge clk_sys);
    sleepMode     <= s;
    deepSleepMode <= d;
    settle();
    chk({27'h0, portClockEnable}, e);
  endtask

  task automatic t_modes();
    wr(`PCG_OFS_RUN_PORT, 32'h00000001);
    wr(`PCG_OFS_SLEEP_PORT, 32'h00000002);
    wr(`PCG_OFS_DEEP_PORT, 32'h00000004);
    rdc(`PCG_OFS_DEEP_PORT, 32'h00000004, `PCG_RESP_OKAY);
    rdc(`PCG_OFS_SLEEP_PORT, 32'h00000002, `PCG_RESP_OKAY);
    mode(1'b1, 1'b0, 32'h00000001);
    mode(1'b0, 1'b1, 32'h00000001);
    wr(`PCG_OFS_RUN_CFG, 32'h00000001 << `PCG_BIT_AUTO_GATE);
    rdc(`PCG_OFS_RUN_CFG, 32'h00000001 << `PCG_BIT_AUTO_GATE, `PCG_RESP_OKAY);
    mode(1'b1, 1'b0, 32'h00000002);
    mode(1'b0, 1'b1, 32'h00000004);
    mode(1'b0, 1'b0, 32'h00000001);
  endtask

  // clock enable low stalls the bus and freezes the gates despite a mode change
  task automatic t_freeze();
    @(posedge clk_sys);
    ce        <= 1'b0;
    sleepMode <= 1'b1;
    fork
      wr(`PCG_OFS_RUN_PORT, 32'h00000008);
      begin
        repeat (4) @(negedge clk_sys);
        chk({31'h0, avs_waitrequest}, 32'h00000001);
        chk({27'h0, portClockEnable}, 32'h00000001);
        @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    settle();
    chk({27'h0, portClockEnable}, 32'h00000002);
    mode(1'b0, 1'b0, 32'h00000008);
  endtask

  // a reset in mid-run must clear gates that are already set
  task automatic t_rereset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
  endtask

  task automatic t_unmapped();
    wr(12'h200, 32'hFFFFFFFF);
    rdc(12'h200, 32'h00000000, `PCG_RESP_DECERR);
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    rstn = 1'b0;
    ce = 1'b1;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    sleepMode = 1'b0;
    deepSleepMode = 1'b0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_ports();
    t_units();
    t_fault();
    t_modes();
    t_freeze();
    t_unmapped();
    t_rereset();
    close_out();
  end

  // about 210 cycles of tests expected
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    close_out();
  end
endmodule
